// ---- gtm_map.svh ----
// Register offsets, field positions, reset values and counts of the timer.
// Assumes a 12-bit APB byte address with one aligned 32-bit word each.
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH
`define GTM_CFG_OFF   12'h000
`define GTM_MRA_OFF   12'h004
`define GTM_MRB_OFF   12'h008
`define GTM_CTL_OFF   12'h00c
`define GTM_IMR_OFF   12'h018
`define GTM_RIS_OFF   12'h01c
`define GTM_MIS_OFF   12'h020
`define GTM_ICR_OFF   12'h024
`define GTM_ILRA_OFF  12'h028
`define GTM_ILRB_OFF  12'h02c
`define GTM_MTA_OFF   12'h030
`define GTM_MTB_OFF   12'h034
`define GTM_PRA_OFF   12'h038
`define GTM_PRB_OFF   12'h03c
`define GTM_PMA_OFF   12'h040
`define GTM_PMB_OFF   12'h044
`define GTM_CNTA_OFF  12'h048
`define GTM_CNTB_OFF  12'h04c
`define GTM_CFG_32    3'h0
`define GTM_CFG_RTC   3'h1
`define GTM_CFG_16    3'h4
`define GTM_MR_ONE    2'h1
`define GTM_MR_PER    2'h2
`define GTM_MR_CAP    2'h3
`define GTM_MR_CMR    2
`define GTM_MR_AMS    3
`define GTM_CTL_EN    0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVL   2
`define GTM_CTL_PWML  6
`define GTM_HALF_SH   8
`define GTM_EV_TO     0
`define GTM_EV_CM     1
`define GTM_EV_CE     2
`define GTM_EV_RTC    3
`define GTM_EV_W      11
`define GTM_CNT_RST   16'hffff
`define GTM_PR_RST    8'h00
`define GTM_RTC_START 32'h0000_0001
`define GTM_RTC_HZ    32768
`endif

// ---- gtm_pin_model.sv ----
// Far-side signal source on the two capture pins of the timer.
// Assumes the bench calls pulse right after a rising clock edge.
module gtm_pin_model (
  input  wire logic pclk,
  input  wire logic ev_out,
  input  wire logic ev_oe_n,
  input  wire logic od_out,
  input  wire logic od_oe_n,
  output logic      ev_pin,
  output logic      od_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ev_src = 1'h0;
  logic od_src = 1'h0;
  // The timer owns a wire only while its enable is low.
  assign ev_pin = ev_oe_n ? ev_src : ev_out;
  assign od_pin = od_oe_n ? od_src : od_out;
  // Each level holds four clocks so every edge survives the synchroniser.
  task automatic pulse(input logic odd, input int n);
    repeat (n) begin
      if (odd) od_src <= 1'h1;
      else ev_src <= 1'h1;
      repeat (4) @(posedge pclk);
      od_src <= 1'h0;
      ev_src <= 1'h0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulse
endmodule : gtm_pin_model

// ---- gtm_pkg.sv ----
// Types shared by the timer files.
// Assumes nothing beyond the map header for numbers.
package gtm_pkg;
  typedef logic [15:0] gtm_cnt_t;
  typedef logic [7:0]  gtm_pre_t;
  typedef enum logic [2:0] {
    GTM_IDLE, GTM_ONESHOT, GTM_PERIODIC,
    GTM_EDGE_CNT, GTM_EDGE_TIME, GTM_PWM
  } gtm_fn_e;
endpackage : gtm_pkg

// ---- gtm_rtc_div.sv ----
// Divides settled rising edges of the slow clock pin to a one-second tick.
// Assumes edges come from gtm_sync, one pulse per input period.
module gtm_rtc_div #(
  parameter int unsigned DIV = 32768
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en,
  input  wire logic edge_in,
  output logic      tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!en) begin
        cnt <= '0;
      end else if (edge_in) begin
        if (cnt == LAST) begin
          cnt  <= '0;
          tick <= 1'b1; // R9
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
  property p_div_tick;
    @(posedge pclk) disable iff (!presetn)
      tick |-> cnt == '0 && $past(cnt) == LAST;
  endproperty
  a_div_tick: assert property (p_div_tick) // R9
    else $error("rtc tick without full count");
endmodule : gtm_rtc_div

// ---- gtm_sync.sv ----
// Three-stage pin synchroniser with settled level and edge pulses.
// Assumes pin is asynchronous to pclk.
module gtm_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s0, s1, s2, lvl;
  // A change counts only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0   <= 1'b0;
      s1   <= 1'b0;
      s2   <= 1'b0;
      lvl  <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s0   <= pin;
      s1   <= s0;
      s2   <= s1;
      if (s1 == s2) begin
        lvl <= s2;
      end
      rise <= (s1 == s2) & s2 & ~lvl; // R18
      fall <= (s1 == s2) & ~s2 & lvl;
    end
  end
endmodule : gtm_sync

// ---- gtm_top.sv ----
// Dual 16-bit general timer with APB register access and two pin halves.
// Assumes pins are routed here only after the port mux selects the timer.
// Function
// [R1] Two 16-bit halves, alone or joined 32-bit
// [R2] 32-bit configuration runs only the joined timer
// [R3] 16-bit configuration: any mode pair per half
// [R4] Reset leaves block idle, controls cleared
// [R5] Reset sets counters and loads to ones
// [R6] Reset clears prescale counters and registers
// [R7] 8-bit prescaler only in one-shot, periodic
// [R8] One-shot, periodic; optional stall on debug halt
// [R9] Real-time mode counts 32.768 kHz pin input
// [R10] Capture halves count or timestamp edges
// [R11] PWM output with selectable inversion
// [R12] Each half: counter, match, prescale, load
// [R13] Pin mux must select timer first
// [R14] Config 0, 1, 4 select modes
// [R15] Zero reloads next cycle; one-shot stops
// [R16] Sticky time-out flag; mask gives masked flag
// [R17] 32-bit access splits upper, lower halves
// [R18] Pins synchronised to system clock
`include "gtm_map.svh"
module gtm_top #(
  parameter int unsigned RTC_DIV = `GTM_RTC_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dbg_halt,
  input  wire logic        even_capture_pin_in,
  output logic             even_capture_pin_out,
  output logic             even_capture_pin_oe_n,
  input  wire logic        odd_capture_pin_in,
  output logic             odd_capture_pin_out,
  output logic             odd_capture_pin_oe_n
);
  logic [2:0]         timer_config_select;
  logic [3:0]         half_mode_reg [2];
  logic [15:0]        ctl;
  logic [`GTM_EV_W-1:0] event_mask_reg, raw_event_status, ev_set, ev_clr;
  gtm_pkg::gtm_cnt_t  half_interval_load [2];
  gtm_pkg::gtm_cnt_t  half_match [2];
  gtm_pkg::gtm_cnt_t  half_counter [2];
  gtm_pkg::gtm_cnt_t  half_capture [2];
  gtm_pkg::gtm_pre_t  half_prescale [2];
  gtm_pkg::gtm_pre_t  half_pre_match [2];
  gtm_pkg::gtm_pre_t  pre_count [2];
  gtm_pkg::gtm_fn_e   fn [2];
  logic [1:0]         pin_in, rise, fall, pwm_q, oe_n_q;
  logic [1:0]         to16, cm16, ce16, en_clr16, wr_ilr;
  logic [31:0]        next_prdata, c32, l32, m32, next32;
  logic               mapped, setup_acc, wr, is32, isrtc, is16;
  logic               run32, to32, rtc_ev, rtc_load, rtc_tick;
  assign setup_acc = psel & penable & ~pready;
  assign wr        = psel & penable & pready & pwrite;
  assign is32  = timer_config_select == `GTM_CFG_32;  // R14
  assign isrtc = timer_config_select == `GTM_CFG_RTC; // R14
  assign is16  = timer_config_select == `GTM_CFG_16;  // R14
  assign c32 = {half_counter[1], half_counter[0]};
  assign l32 = {half_interval_load[1], half_interval_load[0]};
  assign m32 = {half_match[1], half_match[0]};
  assign wr_ilr[0] = wr && paddr == `GTM_ILRA_OFF;
  assign wr_ilr[1] = wr && paddr == `GTM_ILRB_OFF && is16;
  assign pin_in = {odd_capture_pin_in, even_capture_pin_in};
  assign even_capture_pin_out  = pwm_q[0];
  assign odd_capture_pin_out   = pwm_q[1];
  assign even_capture_pin_oe_n = oe_n_q[0];
  assign odd_capture_pin_oe_n  = oe_n_q[1];

  // A one-wait-state slave: data are registered, so pready follows setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_acc;
      pslverr <= setup_acc & ~mapped;
      if (setup_acc) begin
        prdata <= next_prdata;
      end
    end
  end

  always_comb begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `GTM_CFG_OFF: next_prdata = {29'h0, timer_config_select};
      `GTM_MRA_OFF: next_prdata = {28'h0, half_mode_reg[0]};
      `GTM_MRB_OFF: next_prdata = {28'h0, half_mode_reg[1]};
      `GTM_CTL_OFF: next_prdata = {16'h0, ctl};
      `GTM_IMR_OFF: next_prdata = {21'h0, event_mask_reg};
      `GTM_RIS_OFF: next_prdata = {21'h0, raw_event_status};
      `GTM_MIS_OFF:
        next_prdata = {21'h0, raw_event_status & event_mask_reg}; // R16
      `GTM_ICR_OFF: next_prdata = 32'h0000_0000;
      `GTM_ILRA_OFF:
        next_prdata = is16 ? {16'h0, half_interval_load[0]} : l32; // R17
      `GTM_ILRB_OFF: next_prdata = {16'h0, half_interval_load[1]};
      `GTM_MTA_OFF:
        next_prdata = is16 ? {16'h0, half_match[0]} : m32;
      `GTM_MTB_OFF: next_prdata = {16'h0, half_match[1]};
      `GTM_PRA_OFF: next_prdata = {24'h0, half_prescale[0]};
      `GTM_PRB_OFF: next_prdata = {24'h0, half_prescale[1]};
      `GTM_PMA_OFF: next_prdata = {24'h0, half_pre_match[0]};
      `GTM_PMB_OFF: next_prdata = {24'h0, half_pre_match[1]};
      `GTM_CNTA_OFF: begin
        if (!is16) begin
          next_prdata = c32; // R17
        end else if (fn[0] == gtm_pkg::GTM_EDGE_TIME) begin
          next_prdata = {16'h0, half_capture[0]};
        end else begin
          next_prdata = {16'h0, half_counter[0]};
        end
      end
      `GTM_CNTB_OFF: begin
        if (fn[1] == gtm_pkg::GTM_EDGE_TIME) begin
          next_prdata = {16'h0, half_capture[1]};
        end else begin
          next_prdata = {16'h0, half_counter[1]};
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  // Entering real-time mode from another configuration arms the start load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_config_select <= `GTM_CFG_32; // R4
      half_mode_reg[0]    <= 4'h0;
      half_mode_reg[1]    <= 4'h0;
      event_mask_reg      <= '0;
      rtc_load            <= 1'b0;
    end else begin
      rtc_load <= 1'b0;
      if (wr && paddr == `GTM_CFG_OFF) begin
        timer_config_select <= pwdata[2:0];
        rtc_load <= pwdata[2:0] == `GTM_CFG_RTC && !isrtc;
      end
      if (wr && paddr == `GTM_MRA_OFF) half_mode_reg[0] <= pwdata[3:0];
      if (wr && paddr == `GTM_MRB_OFF) half_mode_reg[1] <= pwdata[3:0];
      if (wr && paddr == `GTM_IMR_OFF) begin
        event_mask_reg <= pwdata[`GTM_EV_W-1:0];
      end
    end
  end

  // Load, match and prescale registers; a joined-mode load or match write to half A fills both halves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        half_interval_load[i] <= `GTM_CNT_RST; // R5
        half_match[i]         <= `GTM_CNT_RST;
        half_prescale[i]      <= `GTM_PR_RST;  // R6
        half_pre_match[i]     <= `GTM_PR_RST;
      end
    end else if (wr) begin
      unique case (paddr)
        `GTM_ILRA_OFF: begin
          half_interval_load[0] <= pwdata[15:0];
          if (!is16) half_interval_load[1] <= pwdata[31:16]; // R17
        end
        `GTM_ILRB_OFF: half_interval_load[1] <= pwdata[15:0];
        `GTM_MTA_OFF: begin
          half_match[0] <= pwdata[15:0];
          if (!is16) half_match[1] <= pwdata[31:16];
        end
        `GTM_MTB_OFF: half_match[1] <= pwdata[15:0];
        `GTM_PRA_OFF: half_prescale[0] <= pwdata[7:0];
        `GTM_PRB_OFF: half_prescale[1] <= pwdata[7:0];
        `GTM_PMA_OFF: half_pre_match[0] <= pwdata[7:0];
        `GTM_PMB_OFF: half_pre_match[1] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Hardware clearing of an enable overrides a software write in that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 16'h0000; // R4
    end else begin
      if (wr && paddr == `GTM_CTL_OFF) ctl <= pwdata[15:0];
      if (en_clr16[0] || (to32 && half_mode_reg[0][1:0] == `GTM_MR_ONE)) begin
        ctl[`GTM_CTL_EN] <= 1'b0; // R15
      end
      if (en_clr16[1]) ctl[`GTM_HALF_SH + `GTM_CTL_EN] <= 1'b0;
    end
  end

  // Sticky events: a set in the clearing cycle survives.
  assign ev_clr = (wr && paddr == `GTM_ICR_OFF) ? pwdata[`GTM_EV_W-1:0] : '0;
  always_comb begin
    ev_set = '0;
    ev_set[`GTM_EV_TO]  = to16[0] | to32;
    ev_set[`GTM_EV_CM]  = cm16[0];
    ev_set[`GTM_EV_CE]  = ce16[0];
    ev_set[`GTM_EV_RTC] = rtc_ev;
    ev_set[`GTM_HALF_SH + `GTM_EV_TO] = to16[1];
    ev_set[`GTM_HALF_SH + `GTM_EV_CM] = cm16[1];
    ev_set[`GTM_HALF_SH + `GTM_EV_CE] = ce16[1];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_event_status <= '0;
    end else begin
      raw_event_status <= (raw_event_status & ~ev_clr) | ev_set; // R16
    end
  end

  gtm_rtc_div #(.DIV(RTC_DIV)) u_rtc_div (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (isrtc & ctl[`GTM_CTL_EN]),
    .edge_in (rise[0]),
    .tick    (rtc_tick)
  );

  // Joined counter: down-counter for one-shot/periodic, up for real time.
  assign run32 = ctl[`GTM_CTL_EN] & ~(ctl[`GTM_CTL_STALL] & dbg_halt); // R8
  always_comb begin
    next32 = c32;
    to32   = 1'b0;
    rtc_ev = 1'b0;
    if (is32) begin
      if (wr_ilr[0]) begin
        next32 = pwdata;
      end else if (run32) begin
        if (c32 == 32'h0000_0000) begin
          next32 = l32; // R15
          to32   = 1'b1; // R16
        end else begin
          next32 = c32 - 32'h0000_0001;
        end
      end
    end else if (isrtc) begin
      if (rtc_load) begin
        next32 = `GTM_RTC_START;
      end else if (ctl[`GTM_CTL_EN] && rtc_tick) begin // R9
        if (c32 == m32) begin
          next32 = 32'h0000_0000;
          rtc_ev = 1'b1;
        end else begin
          next32 = c32 + 32'h0000_0001;
        end
      end
    end
  end

  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam int CB = h * `GTM_HALF_SH;
    logic               en, run, hit;
    logic [1:0]         evl;
    gtm_pkg::gtm_cnt_t  ncnt, ncap;
    gtm_pkg::gtm_pre_t  npc;
    assign en  = ctl[CB + `GTM_CTL_EN];
    assign run = en & ~(ctl[CB + `GTM_CTL_STALL] & dbg_halt); // R8
    assign evl = ctl[CB + `GTM_CTL_EVL +: 2];
    assign hit = (evl == 2'h1) ? fall[h] :
                 (evl == 2'h3) ? (rise[h] | fall[h]) : rise[h];

    gtm_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (pin_in[h]),
      .rise    (rise[h]),
      .fall    (fall[h])
    );

    always_comb begin
      fn[h] = gtm_pkg::GTM_IDLE; // R2
      if (is16) begin // R3
        unique case (half_mode_reg[h][1:0])
          `GTM_MR_ONE: fn[h] = gtm_pkg::GTM_ONESHOT;
          `GTM_MR_PER: fn[h] = gtm_pkg::GTM_PERIODIC;
          `GTM_MR_CAP: begin
            if (half_mode_reg[h][`GTM_MR_AMS]) begin
              fn[h] = gtm_pkg::GTM_PWM;
            end else if (half_mode_reg[h][`GTM_MR_CMR]) begin
              fn[h] = gtm_pkg::GTM_EDGE_TIME;
            end else begin
              fn[h] = gtm_pkg::GTM_EDGE_CNT;
            end
          end
          default: fn[h] = gtm_pkg::GTM_IDLE;
        endcase
      end
    end

    always_comb begin
      ncnt = half_counter[h];
      npc  = pre_count[h];
      ncap = half_capture[h];
      to16[h] = 1'b0;
      cm16[h] = 1'b0;
      ce16[h] = 1'b0;
      en_clr16[h] = 1'b0;
      unique case (fn[h])
        gtm_pkg::GTM_ONESHOT, gtm_pkg::GTM_PERIODIC: begin
          if (wr_ilr[h]) begin
            ncnt = pwdata[15:0];
            npc  = half_prescale[h];
          end else if (run && npc != 8'h00) begin
            npc = pre_count[h] - 8'h01; // R7
          end else if (run) begin
            npc = half_prescale[h];
            if (half_counter[h] == 16'h0000) begin
              ncnt = half_interval_load[h]; // R15
              to16[h] = 1'b1;
              en_clr16[h] = fn[h] == gtm_pkg::GTM_ONESHOT;
            end else begin
              ncnt = half_counter[h] - 16'h0001;
            end
          end
        end
        gtm_pkg::GTM_EDGE_CNT: begin
          if (run && hit) begin // R10
            if (half_counter[h] == half_match[h]) begin
              ncnt = half_interval_load[h];
              cm16[h] = 1'b1;
              en_clr16[h] = 1'b1;
            end else begin
              ncnt = half_counter[h] - 16'h0001;
            end
          end
        end
        gtm_pkg::GTM_EDGE_TIME, gtm_pkg::GTM_PWM: begin
          if (run) begin
            ncnt = (half_counter[h] == 16'h0000) ?
                   half_interval_load[h] : half_counter[h] - 16'h0001;
            if (hit && fn[h] == gtm_pkg::GTM_EDGE_TIME) begin
              ncap = half_counter[h]; // R10
              ce16[h] = 1'b1;
            end
          end
        end
        gtm_pkg::GTM_IDLE: ;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        half_counter[h] <= `GTM_CNT_RST; // R5
        pre_count[h]    <= `GTM_PR_RST;  // R6
        half_capture[h] <= 16'h0000;
      end else if (!is16) begin
        half_counter[h] <= next32[16*h +: 16]; // R1
        pre_count[h]    <= `GTM_PR_RST;
      end else begin
        half_counter[h] <= ncnt; // R12
        pre_count[h]    <= npc;
        half_capture[h] <= ncap;
      end
    end

    // The pin is driven only in PWM mode; otherwise it stays an input.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pwm_q[h]  <= 1'b0;
        oe_n_q[h] <= 1'b1; // R13
      end else begin
        oe_n_q[h] <= !(fn[h] == gtm_pkg::GTM_PWM && en);
        pwm_q[h]  <= fn[h] == gtm_pkg::GTM_PWM && en &&
                     ((half_counter[h] > half_match[h]) ^
                      ctl[CB + `GTM_CTL_PWML]); // R11
      end
    end
  end

  logic seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= 1'b0;
    else seen <= 1'b1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rst_cnt;
    !seen |-> half_counter[0] == 16'hffff && half_counter[1] == 16'hffff
      && half_interval_load[0] == 16'hffff
      && half_interval_load[1] == 16'hffff;
  endproperty
  a_rst_cnt: assert property (p_rst_cnt) // R5
    else $error("counters or loads not all ones after reset");
  property p_rst_pre;
    !seen |-> pre_count[0] == 8'h00 && pre_count[1] == 8'h00
      && half_prescale[0] == 8'h00 && half_prescale[1] == 8'h00;
  endproperty
  a_rst_pre: assert property (p_rst_pre) // R6
    else $error("prescale not zero after reset");
  property p_rst_idle;
    !seen |-> ctl == 16'h0000 && oe_n_q == 2'b11;
  endproperty
  a_rst_idle: assert property (p_rst_idle) // R4
    else $error("block active after reset");
  property p_one32;
    is32 && run32 && !wr && c32 == 32'h0 &&
      half_mode_reg[0][1:0] == 2'h1 |=> !ctl[0] && c32 == $past(l32);
  endproperty
  a_one32: assert property (p_one32) // R15
    else $error("one-shot did not reload and stop");
  property p_to_hold;
    raw_event_status[0] && !(wr && paddr == 12'h024 && pwdata[0])
      |=> raw_event_status[0];
  endproperty
  a_to_hold: assert property (p_to_hold) // R16
    else $error("time-out flag lost without clear");
  property p_stall;
    is32 && ctl[0] && ctl[1] && dbg_halt && !wr |=> $stable(c32);
  endproperty
  a_stall: assert property (p_stall) // R8
    else $error("counter moved during stalled halt");
  property p_only32;
    !is16 |=> oe_n_q == 2'b11 ##1 oe_n_q == 2'b11 || is16;
  endproperty
  a_only32: assert property (p_only32) // R2
    else $error("half pin driven in joined mode");
  property p_pre;
    fn[0] == gtm_pkg::GTM_ONESHOT && run32 && pre_count[0] != 8'h00
      && !wr_ilr[0] && is16 |=> $stable(half_counter[0]);
  endproperty
  a_pre: assert property (p_pre) // R7
    else $error("counter stepped before prescale ran out");
  property p_rtc;
    isrtc && ctl[0] && rtc_tick && !rtc_load && c32 == m32
      |=> c32 == 32'h0 && raw_event_status[3];
  endproperty
  a_rtc: assert property (p_rtc) // R9
    else $error("real-time match did not roll over");
  property p_cap;
    is16 && fn[1] == gtm_pkg::GTM_EDGE_TIME && g_half[1].run && rise[1]
      && ctl[11:10] == 2'b00 |=> half_capture[1] == $past(half_counter[1])
      && raw_event_status[10];
  endproperty
  a_cap: assert property (p_cap) // R10
    else $error("edge time not captured");
  property p_word;
    setup_acc && !pwrite && paddr == 12'h048 && !is16
      |=> prdata == {$past(half_counter[1]), $past(half_counter[0])};
  endproperty
  a_word: assert property (p_word) // R17
    else $error("joined count read in wrong order");
  c_mixed: cover property (fn[0] == gtm_pkg::GTM_PWM &&
                           fn[1] == gtm_pkg::GTM_EDGE_CNT);
  c_one32: cover property (to32 ##1 !ctl[0]);
  c_rtc:   cover property (rtc_ev);
  c_cap:   cover property (ce16[0]);
endmodule : gtm_top

// ---- gtm_top_tb.sv ----
// Self-checking bench for the dual half timer, driven over APB.
// Assumes the map header offsets and a pin model on both pins.
`include "gtm_map.svh"
module gtm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        dbg_halt = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ev_pin;
  logic        ev_out;
  logic        ev_oe_n;
  logic        od_pin;
  logic        od_out;
  logic        od_oe_n;
  logic [31:0] rq;
  logic        rerr;
  logic        o1;
  int          bad_count = 0;
  int          n_tests = 0;
  always #5 pclk = ~pclk;
  gtm_top #(.RTC_DIV(4)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dbg_halt(dbg_halt),
    .even_capture_pin_in(ev_pin), .even_capture_pin_out(ev_out),
    .even_capture_pin_oe_n(ev_oe_n), .odd_capture_pin_in(od_pin),
    .odd_capture_pin_out(od_out), .odd_capture_pin_oe_n(od_oe_n));
  gtm_pin_model pm (.pclk(pclk), .ev_out(ev_out), .ev_oe_n(ev_oe_n),
    .od_out(od_out), .od_oe_n(od_oe_n), .ev_pin(ev_pin),
    .od_pin(od_pin));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  // Request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      bad_count++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rq & m);
  endtask : rc
  task automatic t_reset();
    rc(`GTM_CFG_OFF, 32'hffffffff, 32'h0, "cfg");
    rc(`GTM_CTL_OFF, 32'hffffffff, 32'h0, "ctl");
    rc(`GTM_ILRA_OFF, 32'hffffffff, 32'hffffffff, "ld");
    rc(`GTM_CNTA_OFF, 32'hffffffff, 32'hffffffff, "cnt");
    rc(`GTM_PRA_OFF, 32'hff, 32'h0, "pra");
    rc(`GTM_PRB_OFF, 32'hff, 32'h0, "prb");
    rc(12'h0f0, 32'hffffffff, 32'h0, "hole");
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("oe_n", 32'h1, {31'h0, ev_oe_n});
  endtask : t_reset
  task automatic t_join();
    wr(`GTM_ILRA_OFF, 32'h0001_8000);
    rc(`GTM_ILRB_OFF, 32'hffff, 32'h1, "ldb");
    wr(`GTM_MRA_OFF, 32'h2);
    wr(`GTM_CTL_OFF, 32'h1);
    rc(`GTM_CNTA_OFF, 32'hffff0000, 32'h10000, "cnt32");
    wr(`GTM_CTL_OFF, 32'h0);
    wr(`GTM_CFG_OFF, 32'h1);
    rc(`GTM_CNTA_OFF, 32'hffffffff, 32'h1, "rtc0");
    wr(`GTM_MTA_OFF, 32'h2);
    wr(`GTM_CTL_OFF, 32'h1);
    pm.pulse(1'h0, 5);
    rc(`GTM_CNTA_OFF, 32'hffffffff, 32'h2, "rtc1");
    pm.pulse(1'h0, 4);
    rc(`GTM_CNTA_OFF, 32'hffffffff, 32'h0, "rtc2");
    rc(`GTM_RIS_OFF, 32'h8, 32'h8, "rtcev");
    wr(`GTM_CTL_OFF, 32'h0);
  endtask : t_join
  task automatic t_halves();
    wr(`GTM_CFG_OFF, 32'h4);
    wr(`GTM_MRA_OFF, 32'hb);
    wr(`GTM_ILRA_OFF, 32'h20);
    wr(`GTM_MTA_OFF, 32'h10);
    // The joined modes left the second half elsewhere: preload all ones.
    wr(`GTM_MRB_OFF, 32'h2);
    wr(`GTM_ILRB_OFF, 32'hffff);
    wr(`GTM_MRB_OFF, 32'h3);
    wr(`GTM_MTB_OFF, 32'hfffd);
    wr(`GTM_CTL_OFF, 32'h103);
    repeat (2) @(posedge pclk);
    chk("pwm_oe", 32'h0, {31'h0, ev_oe_n});
    dbg_halt <= 1'h1;
    apb(1'h0, `GTM_CNTA_OFF, 32'h0);
    rc(`GTM_CNTA_OFF, 32'hffff, rq & 32'hffff, "stall");
    o1 = ev_out;
    wr(`GTM_CTL_OFF, 32'h143);
    repeat (2) @(posedge pclk);
    chk("inv", {31'h0, ~o1}, {31'h0, ev_out});
    dbg_halt <= 1'h0;
    pm.pulse(1'h1, 2);
    rc(`GTM_RIS_OFF, 32'h200, 32'h0, "ec2");
    pm.pulse(1'h1, 1);
    rc(`GTM_RIS_OFF, 32'h200, 32'h200, "ec3");
    rc(`GTM_CTL_OFF, 32'h100, 32'h0, "ecoff");
    wr(`GTM_MRB_OFF, 32'h7);
    wr(`GTM_CTL_OFF, 32'h100);
    pm.pulse(1'h1, 1);
    rc(`GTM_RIS_OFF, 32'h400, 32'h400, "cap");
    wr(`GTM_CTL_OFF, 32'h0);
  endtask : t_halves
  task automatic t_oneshot();
    wr(`GTM_MRA_OFF, 32'h1);
    wr(`GTM_PRA_OFF, 32'h1);
    wr(`GTM_ILRA_OFF, 32'h3);
    wr(`GTM_IMR_OFF, 32'h1);
    wr(`GTM_CTL_OFF, 32'h1);
    rq = 32'h0;
    for (int k = 0; k < 10 && rq[0] !== 1'h1; k++)
      apb(1'h0, `GTM_RIS_OFF, 32'h0);
    rc(`GTM_MIS_OFF, 32'h1, 32'h1, "mis");
    rc(`GTM_CTL_OFF, 32'h1, 32'h0, "stop");
    rc(`GTM_CNTA_OFF, 32'hffff, 32'h3, "reload");
    wr(`GTM_ICR_OFF, 32'h1);
    rc(`GTM_RIS_OFF, 32'h1, 32'h0, "clr");
  endtask : t_oneshot
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_join();
    t_halves();
    t_oneshot();
    summarize();
  end
endmodule : gtm_top_tb
